// ==== pwm_tb_pkg.sv ====
package pwm_tb_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PERIOD_OFS = 8'h04;
    localparam logic [7:0] ACTIVE_OFS = 8'h08;
    localparam logic [7:0] TRIGGER_OFS = 8'h0c;
    localparam logic [7:0] COUNT_OFS = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

    // control register field positions
    localparam int BIT_MODULE_EN = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_SE_PENDING = 12;
    localparam int BIT_SE_IRQ_EN = 11;
    localparam int BIT_IMM_UPDATE = 10;
    localparam int BIT_SYNC_POL = 9;
    localparam int BIT_SYNC_OEN = 8;

    // event bits of the interrupt status and mask registers
    localparam int EV_SPECIAL = 0;
    localparam int EV_PERIOD = 1;
    localparam int EV_SYNC = 2;
    localparam int EV_W = 3;

    // values after reset
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] TRIGGER_RESET = 16'h0000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

// ==== pwm_time_base.sv ====
`timescale 1ns/1ps
module pwm_time_base #(
    parameter int TB_W = 16
) (
    input wire logic clk, // module clock
    input wire logic rst, // async reset, active high
    input wire logic run, // count enable
    input wire logic restart, // force count to zero
    input wire logic [TB_W-1:0] active_period, // terminal count
    input wire logic [TB_W-1:0] trigger, // special event compare point
    output logic [TB_W-1:0] count, // current count
    output logic wrap, // pulse: period completed
    output logic hit // pulse: special event point reached
);

    typedef struct packed {
        logic [TB_W-1:0] count;
        logic wrap;
        logic hit;
    } tb_state_t;

    tb_state_t state_reg;
    tb_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        state_next.wrap = 1'b0;
        state_next.hit = 1'b0;
        if (restart)
        begin
            state_next.count = '0;
        end
        else if (run)
        begin
            state_next.hit = (state_reg.count == trigger);
            // >= so that a period shrunk below the count still wraps
            if (state_reg.count >= active_period)
            begin
                state_next.count = '0;
                state_next.wrap = 1'b1;
            end
            else
            begin
                state_next.count = state_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign count = state_reg.count;
    assign wrap = state_reg.wrap;
    assign hit = state_reg.hit;

    ////////////////////////////////////////////////////////////////////////
    property p_tb_hold;
        @(posedge clk) disable iff (rst)
        (!run && !restart) |=> (count == $past(count)) && !hit;
    endproperty
    a_tb_hold: assert property (p_tb_hold)
        else $error("time base moved while halted");

endmodule // pwm_time_base

// ==== pwm_time_base_sync_control.sv ====
// Summary of operation
// - pending special event shows as a readable status bit, one while pending.
// - special event interrupt reaches the output only while its enable bit is one.
// - immediate update bit loads a written period at once; else load waits.
// - sync input is active high with polarity bit zero, active low with one.
// - sync output pulses only while the sync output enable bit is one.
// - module enable bit zero stops the whole time base.
// - with idle stop set, the time base halts while the CPU is idle.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module pwm_time_base_sync_control #(
    parameter int TB_W = 16
) (
    input wire logic REF_CLK, // 40 MHz module clock
    input wire logic RST, // async reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [pwm_tb_pkg::ADDR_W-1:0] PADDR, // apb byte address
    input wire logic [pwm_tb_pkg::DATA_W-1:0] PWDATA, // apb write data
    output logic [pwm_tb_pkg::DATA_W-1:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic CPU_IDLE, // cpu in idle mode
    input wire logic SYNC_IN, // external sync input
    output logic SYNC_OUT, // sync output pulse
    output logic IRQ // level interrupt
);
    import pwm_tb_pkg::*;

    typedef struct packed {
        logic module_en;
        logic idle_stop;
        logic se_irq_en;
        logic imm_update;
        logic sync_pol;
        logic sync_oen;
        logic [TB_W-1:0] period_buf;
        logic [TB_W-1:0] active_period;
        logic [TB_W-1:0] trigger;
        logic [EV_W-1:0] irq_status;
        logic [EV_W-1:0] irq_mask;
        logic sync_prev;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic sync_out;
        logic irq;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    logic [TB_W-1:0] tb_count;
    logic tb_wrap;
    logic tb_hit;
    logic tb_run;
    logic tb_restart;
    logic sync_active;
    logic sync_edge;
    logic wr_done;
    logic rd_start;
    logic [DATA_W-1:0] rd_word;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == CTRL_OFS) || (a == PERIOD_OFS) || (a == ACTIVE_OFS)
            || (a == TRIGGER_OFS) || (a == COUNT_OFS) || (a == IRQ_STATUS_OFS)
            || (a == IRQ_MASK_OFS);
    endfunction

    function automatic logic [EV_W-1:0] irq_gate(input logic se_en);
        irq_gate = {{(EV_W-1){1'b1}}, se_en};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // time base steering

    assign sync_active = SYNC_IN ^ state_reg.sync_pol;
    assign sync_edge = state_reg.module_en && sync_active && !state_reg.sync_prev;
    assign tb_run = state_reg.module_en && !(CPU_IDLE && state_reg.idle_stop);
    assign tb_restart = !state_reg.module_en || sync_edge;

    pwm_time_base #(
        .TB_W(TB_W)
    ) u_time_base (
        .clk(REF_CLK),
        .rst(RST),
        .run(tb_run),
        .restart(tb_restart),
        .active_period(state_reg.active_period),
        .trigger(state_reg.trigger),
        .count(tb_count),
        .wrap(tb_wrap),
        .hit(tb_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, ready is registered
    assign wr_done = PSEL && PENABLE && PWRITE && state_reg.pready;
    assign rd_start = PSEL && PENABLE && !state_reg.pready;

    always_comb
    begin
        rd_word = '0;
        unique case (PADDR)
            CTRL_OFS:
            begin
                rd_word[BIT_MODULE_EN] = state_reg.module_en;
                rd_word[BIT_IDLE_STOP] = state_reg.idle_stop;
                rd_word[BIT_SE_PENDING] = state_reg.irq_status[EV_SPECIAL];
                rd_word[BIT_SE_IRQ_EN] = state_reg.se_irq_en;
                rd_word[BIT_IMM_UPDATE] = state_reg.imm_update;
                rd_word[BIT_SYNC_POL] = state_reg.sync_pol;
                rd_word[BIT_SYNC_OEN] = state_reg.sync_oen;
            end
            PERIOD_OFS: rd_word[TB_W-1:0] = state_reg.period_buf;
            ACTIVE_OFS: rd_word[TB_W-1:0] = state_reg.active_period;
            TRIGGER_OFS: rd_word[TB_W-1:0] = state_reg.trigger;
            COUNT_OFS: rd_word[TB_W-1:0] = tb_count;
            IRQ_STATUS_OFS: rd_word[EV_W-1:0] = state_reg.irq_status;
            IRQ_MASK_OFS: rd_word[EV_W-1:0] = state_reg.irq_mask;
            default: rd_word = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        state_next.pready = rd_start;
        state_next.pslverr = rd_start && !is_mapped(PADDR);
        state_next.prdata = (rd_start && !PWRITE) ? rd_word : '0;
        state_next.sync_prev = sync_active;

        // deferred period load at the end of each period
        if (tb_wrap)
        begin
            state_next.active_period = state_reg.period_buf;
        end

        // software writes; clears come first so a same-cycle event wins
        if (wr_done)
        begin
            unique case (PADDR)
                CTRL_OFS:
                begin
                    state_next.module_en = PWDATA[BIT_MODULE_EN];
                    state_next.idle_stop = PWDATA[BIT_IDLE_STOP];
                    state_next.se_irq_en = PWDATA[BIT_SE_IRQ_EN];
                    state_next.imm_update = PWDATA[BIT_IMM_UPDATE];
                    state_next.sync_pol = PWDATA[BIT_SYNC_POL];
                    state_next.sync_oen = PWDATA[BIT_SYNC_OEN];
                    if (PWDATA[BIT_SE_PENDING])
                    begin
                        state_next.irq_status[EV_SPECIAL] = 1'b0;
                    end
                end
                PERIOD_OFS:
                begin
                    state_next.period_buf = PWDATA[TB_W-1:0];
                    if (state_reg.imm_update)
                    begin
                        state_next.active_period = PWDATA[TB_W-1:0];
                    end
                end
                TRIGGER_OFS: state_next.trigger = PWDATA[TB_W-1:0];
                IRQ_STATUS_OFS:
                begin
                    state_next.irq_status = state_reg.irq_status & ~PWDATA[EV_W-1:0];
                end
                IRQ_MASK_OFS: state_next.irq_mask = PWDATA[EV_W-1:0];
                default:
                begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end

        if (tb_hit)
        begin
            state_next.irq_status[EV_SPECIAL] = 1'b1;
        end
        if (tb_wrap)
        begin
            state_next.irq_status[EV_PERIOD] = 1'b1;
        end
        if (sync_edge)
        begin
            state_next.irq_status[EV_SYNC] = 1'b1;
        end

        state_next.sync_out = state_reg.sync_oen && tb_wrap;

        state_next.irq = |(state_next.irq_status & state_next.irq_mask
            & irq_gate(state_next.se_irq_en));
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_reg <= '0;
            state_reg.period_buf <= PERIOD_RESET[TB_W-1:0];
            state_reg.active_period <= PERIOD_RESET[TB_W-1:0];
            state_reg.trigger <= TRIGGER_RESET[TB_W-1:0];
            state_reg.irq_mask <= IRQ_MASK_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign PRDATA = state_reg.prdata;
    assign PREADY = state_reg.pready;
    assign PSLVERR = state_reg.pslverr;
    assign SYNC_OUT = state_reg.sync_out;
    assign IRQ = state_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_pending_read;
        @(posedge REF_CLK) disable iff (RST)
        (rd_start && !PWRITE && PADDR == CTRL_OFS)
            |=> PRDATA[BIT_SE_PENDING] == $past(state_reg.irq_status[EV_SPECIAL]);
    endproperty
    a_pending_read: assert property (p_pending_read)
        else $error("pending bit readback wrong");

    property p_se_gate;
        @(posedge REF_CLK) disable iff (RST)
        (!state_reg.se_irq_en && (state_reg.irq_status[EV_W-1:1]
            & state_reg.irq_mask[EV_W-1:1]) == '0) |-> !IRQ;
    endproperty
    a_se_gate: assert property (p_se_gate)
        else $error("special event interrupt raised while disabled");

    property p_imm_load;
        @(posedge REF_CLK) disable iff (RST)
        (wr_done && PADDR == PERIOD_OFS && state_reg.imm_update)
            |=> state_reg.active_period == $past(PWDATA[TB_W-1:0]);
    endproperty
    a_imm_load: assert property (p_imm_load)
        else $error("immediate period load missed");

    property p_deferred_load;
        @(posedge REF_CLK) disable iff (RST)
        (wr_done && PADDR == PERIOD_OFS && !state_reg.imm_update && !tb_wrap)
            |=> $stable(state_reg.active_period);
    endproperty
    a_deferred_load: assert property (p_deferred_load)
        else $error("deferred period loaded early");

    property p_sync_polarity;
        @(posedge REF_CLK) disable iff (RST)
        (state_reg.module_en && (SYNC_IN != state_reg.sync_pol) && !state_reg.sync_prev)
            |=> tb_count == '0 && state_reg.irq_status[EV_SYNC];
    endproperty
    a_sync_polarity: assert property (p_sync_polarity)
        else $error("sync input edge not honoured");

    property p_sync_out_off;
        @(posedge REF_CLK) disable iff (RST)
        SYNC_OUT |-> $past(state_reg.sync_oen) && $past(tb_wrap);
    endproperty
    a_sync_out_off: assert property (p_sync_out_off)
        else $error("sync output driven while disabled");

    property p_sync_out_on;
        @(posedge REF_CLK) disable iff (RST)
        // a zero period wraps every cycle, so the pulse may legally repeat
        (state_reg.sync_oen && tb_wrap) |=> SYNC_OUT
            ##1 (SYNC_OUT == ($past(state_reg.sync_oen) && $past(tb_wrap)));
    endproperty
    a_sync_out_on: assert property (p_sync_out_on)
        else $error("sync output pulse missing");

    property p_module_off;
        @(posedge REF_CLK) disable iff (RST)
        !state_reg.module_en |=> tb_count == '0 && !tb_wrap && !tb_hit;
    endproperty
    a_module_off: assert property (p_module_off)
        else $error("time base ran while module disabled");

    property p_idle_halt;
        @(posedge REF_CLK) disable iff (RST)
        (state_reg.module_en && state_reg.idle_stop && CPU_IDLE && !sync_edge)
            |=> $stable(tb_count);
    endproperty
    a_idle_halt: assert property (p_idle_halt)
        else $error("time base ran in idle with stop set");

    property p_pending_set;
        @(posedge REF_CLK) disable iff (RST)
        tb_hit |=> state_reg.irq_status[EV_SPECIAL];
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("special event did not set pending");

endmodule // pwm_time_base_sync_control

// ==== sync_partner.sv ====
`timescale 1ns/1ps
module sync_partner (
    input wire logic clk, // module clock
    input wire logic rst, // async reset, active high
    input wire logic pol, // set: sync is low active
    input wire logic req, // hold sync active
    input wire logic sync_out, // pulse from the time base
    output logic sync_in, // sync toward the time base
    output logic [15:0] pulses // cycles seen with sync_out high
);
    ////////////////////////////////////////////////////////////////
    // counting high cycles, not edges, so a stretched pulse shows up
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_in <= 1'b0;
            pulses <= 16'h0000;
        end
        else
        begin
            sync_in <= pol ^ req;
            pulses <= pulses + 16'(sync_out);
        end
    end
endmodule // sync_partner

// ==== tb_pwm_time_base_sync_control.sv ====
`timescale 1ns/1ps
module tb_pwm_time_base_sync_control;
    import pwm_tb_pkg::*;
    typedef struct packed {logic er; logic [31:0] e; logic [31:0] m;} note_t;
    localparam logic [31:0] EN = 32'h1 << BIT_MODULE_EN;
    localparam logic [31:0] IDL = 32'h1 << BIT_IDLE_STOP;
    localparam logic [31:0] SEP = 32'h1 << BIT_SE_PENDING;
    localparam logic [31:0] SEI = 32'h1 << BIT_SE_IRQ_EN;
    localparam logic [31:0] IMM = 32'h1 << BIT_IMM_UPDATE;
    localparam logic [31:0] POL = 32'h1 << BIT_SYNC_POL;
    localparam logic [31:0] OEN = 32'h1 << BIT_SYNC_OEN;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic cpu_idle, sync_in, sync_out, irq, pol, req;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdata, rnd, c1;
    logic [15:0] pulses, p0;
    note_t q[$];
    note_t cur;
    int fails = 0;
    int checks = 0;
    ////////////////////////////////////////////////////////////////
    pwm_time_base_sync_control #(.TB_W(16)) DUT (
        .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CPU_IDLE(cpu_idle),
        .SYNC_IN(sync_in), .SYNC_OUT(sync_out), .IRQ(irq)
    );
    sync_partner PARTNER (
        .clk(ref_clk), .rst(rst), .pol(pol), .req(req),
        .sync_out(sync_out), .sync_in(sync_in), .pulses(pulses)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // the expected answer is queued before the request goes out
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic [31:0] e, input logic er);
        int n;
        q.push_back('{er, e & m, m});
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            give_verdict();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready === 1'b1 && q.size() > 0)
        begin
            cur = q.pop_front();
            check("apb", {31'h0, pslverr, prdata & cur.m}, {31'h0, cur.er, cur.e});
        end
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, cpu_idle, pol, req} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rnd = 32'h0000e87d;
        cyc(6);
        rst <= 1'b0;
        rd(CTRL_OFS, 32'h0, '1);
        rd(PERIOD_OFS, 32'h0000ffff, '1);
        rd(TRIGGER_OFS, 32'h0, '1);
        rd(IRQ_MASK_OFS, 32'h0, '1);
        rd(COUNT_OFS, 32'h0, '1);
        wr(ACTIVE_OFS, 32'h00001234);
        rd(ACTIVE_OFS, 32'h0000ffff, '1);
        apb(1'b0, 8'h1c, 32'h0, '1, 32'h0, 1'b1);
        apb(1'b1, 8'h1c, 32'h5, 32'h0, 32'h0, 1'b1);
        $display("test reset done");
        wr(CTRL_OFS, IMM);
        repeat (4)
        begin
            rnd = xs(rnd);
            wr(PERIOD_OFS, rnd);
            rd(ACTIVE_OFS, {16'h0, rnd[15:0]}, '1);
        end
        wr(PERIOD_OFS, 32'h3);
        wr(CTRL_OFS, 32'h0);
        wr(PERIOD_OFS, 32'h7);
        rd(ACTIVE_OFS, 32'h3, '1);
        wr(CTRL_OFS, EN);
        cyc(8);
        rd(ACTIVE_OFS, 32'h7, '1);
        $display("test period done");
        wr(CTRL_OFS, EN | IDL);
        cpu_idle <= 1'b1;
        cyc(2);
        rd(COUNT_OFS, 32'h0, 32'h0);
        c1 = rdata;
        rd(COUNT_OFS, 32'h0, 32'h0);
        check("halted", 64'(rdata === c1), 64'h1);
        wr(CTRL_OFS, EN);
        rd(COUNT_OFS, 32'h0, 32'h0);
        c1 = rdata;
        rd(COUNT_OFS, 32'h0, 32'h0);
        check("running", 64'(rdata === c1), 64'h0);
        cpu_idle <= 1'b0;
        $display("test idle done");
        wr(TRIGGER_OFS, 32'h2);
        wr(IRQ_MASK_OFS, 32'h1);
        cyc(10);
        rd(CTRL_OFS, EN | SEP, '1);
        check("irq", {63'h0, irq}, 64'h0);
        wr(CTRL_OFS, EN | SEI);
        cyc(3);
        check("irq", {63'h0, irq}, 64'h1);
        wr(IRQ_MASK_OFS, 32'h0);
        cyc(3);
        check("irq", {63'h0, irq}, 64'h0);
        wr(IRQ_MASK_OFS, 32'h1);
        wr(CTRL_OFS, SEI);
        wr(CTRL_OFS, SEI | SEP);
        rd(CTRL_OFS, SEI, '1);
        cyc(2);
        check("irq", {63'h0, irq}, 64'h0);
        wr(IRQ_STATUS_OFS, 32'h7);
        rd(IRQ_STATUS_OFS, 32'h0, '1);
        $display("test event done");
        for (int p = 0; p < 2; p++)
        begin
            pol <= p[0];
            wr(CTRL_OFS, p[0] ? EN | POL : EN);
            cyc(3);
            wr(IRQ_STATUS_OFS, 32'h7);
            req <= 1'b1;
            cyc(4);
            rd(IRQ_STATUS_OFS, 32'h4, 32'h4);
            wr(IRQ_STATUS_OFS, 32'h4);
            req <= 1'b0;
            cyc(4);
            rd(IRQ_STATUS_OFS, 32'h0, 32'h4);
        end
        $display("test sync input done");
        pol <= 1'b0;
        wr(PERIOD_OFS, 32'h3);
        wr(CTRL_OFS, EN);
        cyc(10);
        p0 = pulses;
        cyc(40);
        check("sync_out", 64'(pulses - p0), 64'h0);
        wr(CTRL_OFS, EN | OEN);
        cyc(10);
        p0 = pulses;
        cyc(40);
        check("sync_out", 64'(pulses - p0), 64'ha);
        $display("test sync output done");
        give_verdict();
    end
endmodule // tb_pwm_time_base_sync_control
